// ### core/secl_loader.sv
// Serial EEPROM configuration loader with APB registers
//
// Behaviour
// - Strap high means ROM present and used; low or open means absent.
// - Serial data output carries read command and word address to the ROM.
// - Serial clock cycle 4 us at slowest speed code, 800 ns at fastest.
// - Serial clock pin level is caught at reset as the endian selection.
// - With ROM present, configuration bits are taken from serial data input.
// - With ROM absent, serial data input is ignored completely.
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "secl_cfg.svh"

module secl_loader (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SECL_APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rom_present_strap,
  output logic rom_select_out,
  input wire logic rom_serial_clock_in,
  output logic rom_serial_clock_out,
  output logic rom_serial_clock_oe,
  output logic rom_serial_out,
  input wire logic rom_serial_in,
  output logic big_endian_mode,
  output logic load_done,
  output secl_pkg::secl_speed_t onchip_bus_speed_ctrl
);
  import secl_pkg::*;

  // Synchronised pins: {present strap, clock pin, serial data in}
  logic [2:0] pins_s;
  logic present_s, sk_pin_s, din_s;

  secl_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({rom_present_strap, rom_serial_clock_in, rom_serial_in}),
    .q(pins_s)
  );

  assign present_s = pins_s[2];
  assign sk_pin_s = pins_s[1];
  assign din_s = pins_s[0];

  secl_state_t state_r;
  logic [2:0] strap_cnt_r;
  logic [1:0] speed_r;
  logic [`SECL_HALF_W-1:0] half_cnt_r, half_lim;
  logic [`SECL_BIT_W-1:0] bit_cnt_r;
  logic [`SECL_CMD_W-1:0] cmd_sh_r;
  logic [`SECL_DATA_W-1:0] data_sh_r, data_word, mem_rdata;
  logic [`SECL_ADDR_W-1:0] word_idx_r, rd_idx_r;
  logic [`SECL_ADDR_W:0] loaded_cnt_r;
  logic [31:0] rd_mux;
  logic strap_end, present_r, bigend_r, load_req_r, start_load;
  logic speed_wr, reload_wr, abort_wr, half_tick, sk_r, bit_end;
  logic word_we, last_word, done_r, absent_r;
  logic apb_wr, apb_setup, addr_ok, active;

  // APB decode
  assign apb_wr = psel && penable && pwrite;
  assign apb_setup = psel && !penable;
  assign addr_ok = (paddr == `SECL_OFF_CTRL) || (paddr == `SECL_OFF_STATUS) ||
                   (paddr == `SECL_OFF_WADDR) || (paddr == `SECL_OFF_WDATA);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  assign speed_wr = apb_wr && (paddr == `SECL_OFF_CTRL);
  assign reload_wr = speed_wr && pwdata[`SECL_CTRL_RELOAD_BIT];
  assign abort_wr = speed_wr && pwdata[`SECL_CTRL_ABORT_BIT];

  // Bus speed field, reset to slowest
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_r <= `SECL_CTRL_SPEED_RST;
    end else if (speed_wr) begin
      speed_r <= pwdata[`SECL_CTRL_SPEED_LSB +: 2];
    end
  end
  assign onchip_bus_speed_ctrl = speed_r;

  // Word index for register readback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_idx_r <= '0;
    end else if (apb_wr && (paddr == `SECL_OFF_WADDR)) begin
      rd_idx_r <= pwdata[`SECL_ADDR_W-1:0];
    end
  end

  // Strap capture after reset release, once synchronisers have settled
  assign strap_end = (state_r == secl_st_strap) && (strap_cnt_r == `SECL_STRAP_WAIT);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_r <= '0;
    end else if (state_r == secl_st_strap) begin
      strap_cnt_r <= strap_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      present_r <= 1'b0;
      bigend_r <= 1'b0;
    end else if (strap_end) begin
      present_r <= present_s;
      bigend_r <= sk_pin_s;
    end
  end
  assign big_endian_mode = bigend_r;

  // Load request: from strap capture or software; a new request beats the start
  assign start_load = (state_r == secl_st_idle) && load_req_r && present_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_req_r <= 1'b0;
    end else if (strap_end || reload_wr) begin
      load_req_r <= 1'b1;
    end else if (start_load || ((state_r == secl_st_idle) && !present_r)) begin
      load_req_r <= 1'b0;
    end
  end

  // Half period of the serial clock from the speed field
  assign half_lim = (speed_r == `SECL_SPEED_FAST) ? `SECL_HALF_W'(`SECL_SK_FAST_HALF) :
                    `SECL_HALF_W'(`SECL_SK_SLOW_HALF);
  assign active = (state_r == secl_st_cmd) || (state_r == secl_st_data) ||
                  (state_r == secl_st_gap);
  assign half_tick = active && (half_cnt_r >= half_lim - `SECL_HALF_W'(1));
  assign bit_end = half_tick && sk_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt_r <= '0;
    end else if (!active || half_tick) begin
      half_cnt_r <= '0;
    end else begin
      half_cnt_r <= half_cnt_r + `SECL_HALF_W'(1);
    end
  end

  // Serial clock toggles each half period inside a word frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sk_r <= 1'b0;
    end else if (state_r == secl_st_gap || !active) begin
      sk_r <= 1'b0;
    end else if (half_tick) begin
      sk_r <= !sk_r;
    end
  end

  // Pin stays an input until the strap is caught
  assign rom_serial_clock_out = sk_r;
  assign rom_serial_clock_oe = (state_r != secl_st_strap);

  // Sequencer
  assign last_word = (word_idx_r == `SECL_ADDR_W'(`SECL_WORDS - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= secl_st_strap;
    end else begin
      unique case (state_r)
        secl_st_strap: begin
          if (strap_end) begin
            state_r <= secl_st_idle;
          end
        end
        secl_st_idle: begin
          if (start_load) begin
            state_r <= secl_st_cmd;
          end
        end
        secl_st_cmd: begin
          if (abort_wr) begin
            state_r <= secl_st_idle;
          end else if (bit_end && bit_cnt_r == `SECL_BIT_W'(`SECL_CMD_W - 1)) begin
            state_r <= secl_st_data;
          end
        end
        secl_st_data: begin
          if (abort_wr) begin
            state_r <= secl_st_idle;
          end else if (bit_end && bit_cnt_r == `SECL_BIT_W'(`SECL_DATA_W - 1)) begin
            state_r <= secl_st_gap;
          end
        end
        secl_st_gap: begin
          if (abort_wr || (half_tick && last_word)) begin
            state_r <= secl_st_idle;
          end else if (half_tick) begin
            state_r <= secl_st_cmd;
          end
        end
      endcase
    end
  end

  // Bit counter within command and data phases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_r <= '0;
    end else if (state_r == secl_st_gap || state_r == secl_st_idle) begin
      bit_cnt_r <= '0;
    end else if (bit_end && state_r == secl_st_cmd &&
                 bit_cnt_r == `SECL_BIT_W'(`SECL_CMD_W - 1)) begin
      bit_cnt_r <= '0;
    end else if (bit_end) begin
      bit_cnt_r <= bit_cnt_r + `SECL_BIT_W'(1);
    end
  end

  // Word index walks the whole ROM
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_idx_r <= '0;
    end else if (start_load) begin
      word_idx_r <= '0;
    end else if (state_r == secl_st_gap && half_tick && !last_word) begin
      word_idx_r <= word_idx_r + `SECL_ADDR_W'(1);
    end
  end

  // Command shifter: start bit, read opcode, word address, MSB first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_sh_r <= '0;
    end else if (start_load) begin
      cmd_sh_r <= {`SECL_READ_OP, `SECL_ADDR_W'(0)};
    end else if (state_r == secl_st_gap && half_tick) begin
      cmd_sh_r <= {`SECL_READ_OP, word_idx_r + `SECL_ADDR_W'(1)};
    end else if (state_r == secl_st_cmd && bit_end) begin
      cmd_sh_r <= {cmd_sh_r[`SECL_CMD_W-2:0], 1'b0};
    end
  end

  // Data changes while the clock is low, so the ROM sees it stable at the rise
  assign rom_serial_out = (state_r == secl_st_cmd) && cmd_sh_r[`SECL_CMD_W-1];

  // Data shifter: sampled at the end of the high half, after the ROM updated it
  assign data_word = {data_sh_r[`SECL_DATA_W-2:0], din_s && present_r};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_sh_r <= '0;
    end else if (state_r == secl_st_data && bit_end && present_r) begin
      data_sh_r <= data_word;
    end
  end
  assign word_we = (state_r == secl_st_data) && bit_end && present_r &&
                   (bit_cnt_r == `SECL_BIT_W'(`SECL_DATA_W - 1)) && !abort_wr;

  secl_word_mem u_word_mem (
    .clk(pclk),
    .rst_n(presetn),
    .we(word_we),
    .waddr(word_idx_r),
    .wdata(data_word),
    .raddr(rd_idx_r),
    .rdata(mem_rdata)
  );

  // Chip select only inside a word frame
  assign rom_select_out = present_r &&
                          ((state_r == secl_st_cmd) || (state_r == secl_st_data));

  // Load progress and completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_cnt_r <= '0;
    end else if (start_load) begin
      loaded_cnt_r <= '0;
    end else if (word_we) begin
      loaded_cnt_r <= loaded_cnt_r + (`SECL_ADDR_W + 1)'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
    end else if (state_r == secl_st_gap && half_tick && last_word && !abort_wr) begin
      done_r <= 1'b1;
    end else if (start_load) begin
      done_r <= 1'b0;
    end
  end
  assign load_done = done_r;

  // Request made while no ROM is fitted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      absent_r <= 1'b0;
    end else if ((state_r == secl_st_idle) && load_req_r && !present_r) begin
      absent_r <= 1'b1;
    end else if (start_load) begin
      absent_r <= 1'b0;
    end
  end

  // Read data latched in the setup phase
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `SECL_OFF_CTRL: rd_mux[`SECL_CTRL_SPEED_LSB +: 2] = speed_r;
      `SECL_OFF_STATUS: begin
        rd_mux[`SECL_STAT_BUSY_BIT] = active;
        rd_mux[`SECL_STAT_DONE_BIT] = done_r;
        rd_mux[`SECL_STAT_PRESENT_BIT] = present_r;
        rd_mux[`SECL_STAT_BIGEND_BIT] = bigend_r;
        rd_mux[`SECL_STAT_ABSENT_BIT] = absent_r;
        rd_mux[`SECL_STAT_COUNT_LSB +: `SECL_ADDR_W + 1] = loaded_cnt_r;
      end
      `SECL_OFF_WADDR: rd_mux[`SECL_ADDR_W-1:0] = rd_idx_r;
      `SECL_OFF_WDATA: rd_mux[`SECL_DATA_W-1:0] = mem_rdata;
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule

`default_nettype wire

// ### core/secl_cfg.svh
// Constants of the serial configuration loader
`ifndef SECL_CFG_SVH
`define SECL_CFG_SVH

// Timing
`define SECL_CLK_NS 40
`define SECL_SK_SLOW_NS 4000
`define SECL_SK_FAST_NS 800
`define SECL_SK_SLOW_HALF (`SECL_SK_SLOW_NS / (2 * `SECL_CLK_NS))
`define SECL_SK_FAST_HALF (`SECL_SK_FAST_NS / (2 * `SECL_CLK_NS))
`define SECL_HALF_W 7
`define SECL_STRAP_WAIT 3'h4

// Bus speed codes
`define SECL_SPEED_FAST 2'h0
`define SECL_SPEED_SLOW 2'h3

// Serial frame
`define SECL_WORDS 64
`define SECL_ADDR_W 6
`define SECL_DATA_W 16
`define SECL_CMD_W 9
`define SECL_READ_OP 3'h6
`define SECL_BIT_W 5

// Register offsets
`define SECL_APB_AW 12
`define SECL_OFF_CTRL 12'h000
`define SECL_OFF_STATUS 12'h004
`define SECL_OFF_WADDR 12'h008
`define SECL_OFF_WDATA 12'h00C

// Control fields
`define SECL_CTRL_SPEED_LSB 0
`define SECL_CTRL_RELOAD_BIT 2
`define SECL_CTRL_ABORT_BIT 3
`define SECL_CTRL_SPEED_RST 2'h3

// Status fields
`define SECL_STAT_BUSY_BIT 0
`define SECL_STAT_DONE_BIT 1
`define SECL_STAT_PRESENT_BIT 2
`define SECL_STAT_BIGEND_BIT 3
`define SECL_STAT_ABSENT_BIT 4
`define SECL_STAT_COUNT_LSB 8

`endif

// ### core/secl_pkg.sv
// Types of the serial configuration loader
`default_nettype none
package secl_pkg;

  typedef enum logic [2:0] {
    secl_st_strap,
    secl_st_idle,
    secl_st_cmd,
    secl_st_data,
    secl_st_gap
  } secl_state_t;

  typedef logic [1:0] secl_speed_t;

endpackage

`default_nettype wire

// ### core/secl_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none

module secl_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

`default_nettype wire

// ### core/secl_word_mem.sv
// Store of loaded configuration words
`timescale 1ns/10ps
`default_nettype none
`include "secl_cfg.svh"

module secl_word_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [`SECL_ADDR_W-1:0] waddr,
  input wire logic [`SECL_DATA_W-1:0] wdata,
  input wire logic [`SECL_ADDR_W-1:0] raddr,
  output logic [`SECL_DATA_W-1:0] rdata
);

  logic [`SECL_DATA_W-1:0] mem [`SECL_WORDS];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

`default_nettype wire

// ### verif/secl_loader_asserts.sv
// Port checks of the serial configuration loader
`timescale 1ns/10ps
`default_nettype none
`include "secl_cfg.svh"

module secl_loader_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rom_present_strap,
  input wire logic rom_select_out,
  input wire logic rom_serial_clock_in,
  input wire logic rom_serial_clock_out,
  input wire logic rom_serial_clock_oe,
  input wire logic rom_serial_out,
  input wire logic big_endian_mode,
  input wire secl_pkg::secl_speed_t onchip_bus_speed_ctrl
);
  import secl_pkg::*;
  logic sk_q;
  logic cs_q;
  logic [6:0] hc_r;
  // Cycles since the last clock edge or frame start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sk_q <= 1'b0;
      cs_q <= 1'b0;
      hc_r <= 7'h00;
    end else begin
      sk_q <= rom_serial_clock_out;
      cs_q <= rom_select_out;
      if (rom_serial_clock_out != sk_q || (rom_select_out && !cs_q)) hc_r <= 7'h01;
      else if (hc_r != 7'h7F) hc_r <= hc_r + 7'h01;
    end
  end
  sequence s_frame_open;
    rom_select_out [*8];
  endsequence
  sequence s_frame_gap;
    !rom_select_out [*8];
  endsequence
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_absent_quiet: assert property (
    !rom_present_strap |-> !rom_select_out && !$changed(rom_serial_clock_out))
    else $error("select or clock active with rom absent");
  chk_data_on_fall: assert property (
    rom_select_out && cs_q && $changed(rom_serial_out) |-> $fell(rom_serial_clock_out))
    else $error("serial data changed off the falling clock");
  chk_data_idle: assert property (
    !rom_select_out && !cs_q && $past(!rom_select_out, 2) |-> !rom_serial_out)
    else $error("serial data active outside a frame");
  chk_half_period: assert property (
    rom_serial_clock_out != sk_q && cs_q && rom_select_out |->
      hc_r == ((onchip_bus_speed_ctrl == `SECL_SPEED_FAST) ? 7'h0A : 7'h32))
    else $error("serial clock half period wrong");
  chk_endian_catch: assert property (
    $rose(rom_serial_clock_oe) |-> big_endian_mode == $past(rom_serial_clock_in))
    else $error("endian mode not caught from clock pin");
  chk_endian_hold: assert property (
    rom_serial_clock_oe && $past(rom_serial_clock_oe) |-> $stable(big_endian_mode))
    else $error("endian mode changed after strap window");
  chk_clock_idle: assert property (
    !rom_select_out && !cs_q && $past(!rom_select_out, 2) |-> !rom_serial_clock_out)
    else $error("serial clock high outside a frame");
  chk_frame_open: assert property (
    $rose(rom_select_out) |-> s_frame_open)
    else $error("select dropped early in a frame");
  chk_frame_gap: assert property (
    $fell(rom_select_out) |-> s_frame_gap)
    else $error("select gap between words too short");
endmodule

bind secl_loader secl_loader_asserts u_chk (.pclk, .presetn, .rom_present_strap,
  .rom_select_out, .rom_serial_clock_in, .rom_serial_clock_out, .rom_serial_clock_oe,
  .rom_serial_out, .big_endian_mode, .onchip_bus_speed_ctrl);
`default_nettype wire

// ### verif/secl_rom_model.sv
// Behavioural serial configuration memory on the far side of the loader
`timescale 1ns/10ps
`default_nettype none

module secl_rom_model (
  input wire logic cs,
  input wire logic sk,
  input wire logic di,
  output logic do_o,
  output var int bad_cmd
);
  logic [8:0] cmd_r;
  logic [4:0] cnt_r;
  logic bit_r;
  logic [15:0] word;
  assign word = {4'hA, cmd_r[5:0], ~cmd_r[5:0]};
  // Released line falls to its pull-down level
  assign do_o = (cs && cnt_r > 5'h09 && cnt_r < 5'h1A) ? bit_r : 1'b0;
  initial bad_cmd = 0;
  initial cnt_r = 5'h00;
  always @(posedge sk or negedge cs) begin
    if (!cs) begin
      cnt_r <= 5'h00;
    end else begin
      if (cnt_r < 5'h09) cmd_r <= {cmd_r[7:0], di};
      if (cnt_r == 5'h09 && cmd_r[8:6] !== 3'h6) bad_cmd <= bad_cmd + 1;
      if (cnt_r > 5'h08 && cnt_r < 5'h19) bit_r <= word[5'h18 - cnt_r];
      if (cnt_r != 5'h1F) cnt_r <= cnt_r + 5'h01;
    end
  end
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench of the serial configuration loader
`timescale 1ns/10ps
`default_nettype none
`include "secl_cfg.svh"

module tb;
  import secl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic strap, pull, noise, absent, cs, sk_out, sk_oe, sk_pin, do_w, di_w, rom_do, big, done;
  secl_speed_t speed;
  int error_cnt, cmp_count, bad_cmd, a, b, i;
  assign sk_pin = sk_oe ? sk_out : pull;
  assign di_w = absent ? noise : rom_do;
  secl_loader u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rom_present_strap(strap), .rom_select_out(cs),
    .rom_serial_clock_in(sk_pin), .rom_serial_clock_out(sk_out), .rom_serial_clock_oe(sk_oe),
    .rom_serial_out(do_w), .rom_serial_in(di_w), .big_endian_mode(big), .load_done(done),
    .onchip_bus_speed_ctrl(speed));
  secl_rom_model u_rom (.cs, .sk(sk_pin), .di(do_w), .do_o(rom_do), .bad_cmd);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) noise <= ~noise;
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic hang(input string nm);
    error_cnt++;
    $display("FAIL %s expected done seen timeout", nm);
    test_done();
  endtask
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 16) hang("pready");
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset(input logic s, input logic p);
    @(posedge pclk);
    presetn <= 1'b0;
    strap <= s;
    pull <= p;
    absent <= ~s;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 30 && sk_oe !== 1'b1; i++) @(posedge pclk);
    if (i == 30) hang("clock oe");
  endtask
  task automatic wait_sk(input logic v, output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (sk_out !== v && c < 200);
    if (c == 200) hang("serial clock");
  endtask
  task automatic t_absent();
    do_reset(1'b0, 1'b0);
    check("endian low", big, 1'b0);
    check("speed reset", speed, `SECL_CTRL_SPEED_RST);
    apb(1'b1, `SECL_OFF_CTRL, 32'h0000_0007);
    apb(1'b0, `SECL_OFF_STATUS, 32'h0);
    check("status absent", q, 32'h0000_0010);
    for (i = 0, a = 0; i < 200; i++) begin
      @(posedge pclk);
      if (cs !== 1'b0 || sk_out !== 1'b0) a++;
    end
    check("pins quiet", a, 0);
    apb(1'b0, `SECL_OFF_STATUS, 32'h0);
    check("input ignored", q, 32'h0000_0010);
  endtask
  task automatic t_slow();
    do_reset(1'b1, 1'b1);
    check("endian high", big, 1'b1);
    wait_sk(1'b1, a);
    wait_sk(1'b0, a);
    wait_sk(1'b1, b);
    check("slow cycle", a + b, 100);
    check("select in frame", cs, 1'b1);
    apb(1'b1, `SECL_OFF_CTRL, 32'h0000_000B);
    apb(1'b0, `SECL_OFF_STATUS, 32'h0);
    check("status aborted", q, 32'h0000_000C);
    check("select after abort", cs, 1'b0);
  endtask
  task automatic t_fast();
    apb(1'b1, `SECL_OFF_CTRL, 32'h0000_0000);
    apb(1'b1, `SECL_OFF_CTRL, 32'h0000_0004);
    check("speed field", speed, `SECL_SPEED_FAST);
    wait_sk(1'b1, a);
    wait_sk(1'b0, a);
    wait_sk(1'b1, b);
    check("fast cycle", a + b, 20);
    for (i = 0; i < 40000 && done !== 1'b1; i++) @(posedge pclk);
    if (i == 40000) hang("load done");
    apb(1'b0, `SECL_OFF_STATUS, 32'h0);
    check("status loaded", q, 32'h0000_400E);
    check("read commands", bad_cmd, 0);
    for (a = 0; a < 64; a += 21) begin
      apb(1'b1, `SECL_OFF_WADDR, 32'(a));
      apb(1'b0, `SECL_OFF_WDATA, 32'h0);
      check("stored word", q, {16'h0, 4'hA, 6'(a), ~6'(a)});
    end
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped error", {q[30:0], err}, 32'h1);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    strap = 1'b0;
    pull = 1'b0;
    noise = 1'b0;
    absent = 1'b1;
    error_cnt = 0;
    cmp_count = 0;
    t_absent();
    t_slow();
    t_fast();
    test_done();
  end
endmodule
`default_nettype wire
